// ===== include/cirs_defines.vh
// register offsets, field positions, reset values and timing counts for the can interrupt block
`ifndef CIRS_DEFINES_VH
`define CIRS_DEFINES_VH

// ----------------------------------------------------------------------------
// register word offsets (byte address = 4 * index)
// ----------------------------------------------------------------------------
`define CIRS_IDX_FLAGS     4'h3
`define CIRS_IDX_CTRL      4'h8
`define CIRS_IDX_STATUS    4'h9
`define CIRS_IDX_EVT       4'hA
`define CIRS_IDX_EVT_MASK  4'hB
`define CIRS_IDX_FORCED    4'hC

// ----------------------------------------------------------------------------
// interrupt flag register bit positions
// ----------------------------------------------------------------------------
`define CIRS_BIT_RX        0
`define CIRS_BIT_TX        1
`define CIRS_BIT_ERR       2
`define CIRS_BIT_OVR       3
`define CIRS_BIT_WAKE      4

// ----------------------------------------------------------------------------
// control register bit positions (own control word)
// ----------------------------------------------------------------------------
`define CIRS_CTRL_RESET_REQ 0
`define CIRS_CTRL_RX_EN     1
`define CIRS_CTRL_TX_EN     2
`define CIRS_CTRL_ERR_EN    3
`define CIRS_CTRL_OVR_EN    4

// ----------------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------------
`define CIRS_FLAGS_RESET   8'h00
`define CIRS_CTRL_RESET    8'h01
`define CIRS_BUS_FREE_CNT  128

`endif

// ===== logic/cirs_recovery.v
// bus-off recovery counter: waits a number of bus-free occurrences
`timescale 1ns/1ps
`include "cirs_defines.vh"

module cirs_recovery #(
  parameter COUNT = `CIRS_BUS_FREE_CNT
) (
  // clock and reset
  input  wire       clk,
  input  wire       sys_rst,
  // control
  input  wire       start,
  input  wire       bus_free_pulse,
  // result
  output reg        done,
  output wire       busy
);

  reg  [7:0] remaining;
  reg        running;

  assign busy = running;

  // count bus-free pulses; one done pulse when the count runs out
  always @(posedge clk) begin
    if (sys_rst) begin
      remaining <= 8'h00;
      running   <= 1'b0;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !running) begin
        remaining <= COUNT[7:0];
        running   <= 1'b1;
      end else if (running && bus_free_pulse) begin
        if (remaining == 8'h01) begin
          running <= 1'b0;
          done    <= 1'b1;
        end
        remaining <= remaining - 8'h01;
      end
    end
  end

endmodule

// ===== logic/cirs_top.v
// can interrupt flag register with reset-request forcing and avalon slave
`timescale 1ns/1ps
`include "cirs_defines.vh"

// What this block does
// - interrupt request high whenever any implemented flag bit is set
// - flag register read-only; a cpu read clears all flags
// - bits 7..5 reserved read zero; wake flag set on leaving sleep
// - overrun flag set on overrun store while overrun enable high
// - error flag set on error or bus status change while enabled
// - tx flag set on tx buffer locked-to-released edge while enabled
// - rx flag set on new receive message while enabled
// - overrun flag sets in the same cycle as data-overrun status
// - rx flag sets in the same cycle as receive-buffer-full status
// - reset request forces test off, wake, clear and release high, abort and tx low
// - reset request forces idle, complete, released, no overrun, empty; clears overrun, tx and rx flags
// - reference, rx selects high, bus and error low only after external reset
// - entering bus-off sets reset request until cpu clears it
// - after clear wait 128 bus-free occurrences, then bus on, errors cleared
module cirs_top #(
  parameter BUS_FREE_COUNT = `CIRS_BUS_FREE_CNT
) (
  // clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // avalon-mm slave
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // events from the controller core
  input  wire        sleep_exit,
  input  wire        overrun_store,
  input  wire        rx_msg_stored,
  input  wire        tx_buffer_released,
  input  wire        error_warning_status,
  input  wire        bus_off_enter,
  input  wire        bus_free_pulse,
  input  wire        ext_reset_seen,
  // raw status and command from the core
  input  wire        test_mode_in,
  input  wire        sleep_in,
  input  wire        clear_overrun_in,
  input  wire        release_rx_buffer_in,
  input  wire        abort_tx_in,
  input  wire        tx_request_in,
  input  wire        reference_in,
  input  wire        rx_input0_in,
  input  wire        rx_input1_in,
  input  wire        tx_active_in,
  input  wire        rx_active_in,
  input  wire        tx_complete_in,
  // forced views of control, command and status
  output reg         test_mode_bit,
  output reg         sleep_cmd,
  output reg         clear_overrun_cmd,
  output reg         release_rx_buffer_cmd,
  output reg         abort_tx_cmd,
  output reg         tx_request_cmd,
  output reg         reference_output_enable,
  output reg         rx_input0_select,
  output reg         rx_input1_select,
  output reg  [7:0]  status_reg,
  output reg         reset_request,
  output reg         error_counter_clear,
  // interrupts
  output wire        can_irq_request,
  output wire        sys_irq
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  reg  [7:0] irq_flag_reg;
  reg  [7:0] control_reg;
  reg        bus_off_status;
  reg        err_status_q;
  reg        bus_off_q;
  reg        tbs_q;
  reg        ext_reset_latch;
  reg        data_overrun;
  reg        rx_full;
  reg  [2:0] evt_status;
  reg  [2:0] evt_mask;
  reg        rd_ack;
  reg        rr_q;
  reg  [7:0] next_flags;
  reg        next_overrun;
  reg        next_rx_full;
  wire       rec_done;
  wire       rec_busy;
  wire       req_active;
  wire       flags_read;
  wire       bus_off_rise;

  // the reset-request level used for forcing
  assign req_active = reset_request;

  // one-cycle read answer: waitrequest is high on the first cycle of a read
  assign avs_waitrequest = avs_read & ~rd_ack;
  assign flags_read      = avs_read & rd_ack & (avs_address == `CIRS_IDX_FLAGS);
  assign bus_off_rise    = bus_off_enter & ~bus_off_status;

  // --------------------------------------------------------------------------
  // bus-off recovery
  // --------------------------------------------------------------------------
  // recovery starts on the falling edge of reset request while bus-off; a cpu
  // that never clears reset request keeps the controller off the bus for good
  cirs_recovery #(
    .COUNT          (BUS_FREE_COUNT)
  ) u_recovery (
    .clk            (clk),
    .sys_rst        (sys_rst),
    .start          (bus_off_status & ~reset_request & rr_q),
    .bus_free_pulse (bus_free_pulse),
    .done           (rec_done),
    .busy           (rec_busy)
  );

  // read handshake register
  // waitrequest drops in the second cycle of every read; writes never wait
  always @(posedge clk) begin
    if (sys_rst)
      rd_ack <= 1'b0;
    else
      rd_ack <= avs_read & ~rd_ack;
  end

  // --------------------------------------------------------------------------
  // control register and reset request
  // --------------------------------------------------------------------------
  // writes to the control word; bus-off entry overrides a cpu clear of reset request
  // bit0 is reset request, bits 4..1 are the enables that gate the flag sets
  always @(posedge clk) begin
    if (sys_rst) begin
      control_reg <= `CIRS_CTRL_RESET;
      rr_q        <= 1'b0;
    end else begin
      rr_q <= reset_request;
      if (avs_write && avs_address == `CIRS_IDX_CTRL)
        control_reg <= avs_writedata[7:0];
      if (bus_off_rise)
        control_reg[`CIRS_CTRL_RESET_REQ] <= 1'b1;
    end
  end

  always @* begin
    reset_request = control_reg[`CIRS_CTRL_RESET_REQ];
  end

  // bus status: set on bus-off, cleared only when recovery finishes
  always @(posedge clk) begin
    if (sys_rst) begin
      bus_off_status      <= 1'b0;
      error_counter_clear <= 1'b0;
    end else begin
      error_counter_clear <= rec_done;
      if (bus_off_enter)
        bus_off_status <= 1'b1;
      else if (rec_done)
        bus_off_status <= 1'b0;
    end
  end

  // external-reset qualifier: held until the reset request is dropped
  // limitation: an external reset seen while reset request is low is forgotten
  always @(posedge clk) begin
    if (sys_rst)
      ext_reset_latch <= 1'b1;
    else if (ext_reset_seen)
      ext_reset_latch <= 1'b1;
    else if (!reset_request)
      ext_reset_latch <= 1'b0;
  end

  // --------------------------------------------------------------------------
  // local status bits: data overrun and receive buffer full
  // --------------------------------------------------------------------------
  // next values feed both the state and the status view, so the status bits
  // rise in the same cycle as their interrupt flags
  always @* begin
    next_overrun = data_overrun;
    next_rx_full = rx_full;
    if (req_active) begin
      next_overrun = 1'b0;
      next_rx_full = 1'b0;
    end else begin
      if (overrun_store)
        next_overrun = 1'b1;
      else if (clear_overrun_in)
        next_overrun = 1'b0;
      if (rx_msg_stored)
        next_rx_full = 1'b1;
      else if (release_rx_buffer_in)
        next_rx_full = 1'b0;
    end
  end

  // state registers for the two status bits
  always @(posedge clk) begin
    if (sys_rst) begin
      data_overrun <= 1'b0;
      rx_full      <= 1'b0;
    end else begin
      data_overrun <= next_overrun;
      rx_full      <= next_rx_full;
    end
  end

  // --------------------------------------------------------------------------
  // interrupt flag register
  // --------------------------------------------------------------------------
  // sets beat the read clear so an event in the read cycle is kept
  always @* begin
    next_flags = irq_flag_reg;
    if (flags_read)
      next_flags = `CIRS_FLAGS_RESET;
    if (sleep_exit)
      next_flags[`CIRS_BIT_WAKE] = 1'b1;
    if (overrun_store && control_reg[`CIRS_CTRL_OVR_EN])
      next_flags[`CIRS_BIT_OVR] = 1'b1;
    if ((error_warning_status != err_status_q || bus_off_status != bus_off_q)
        && control_reg[`CIRS_CTRL_ERR_EN])
      next_flags[`CIRS_BIT_ERR] = 1'b1;
    if (tx_buffer_released && !tbs_q && control_reg[`CIRS_CTRL_TX_EN])
      next_flags[`CIRS_BIT_TX] = 1'b1;
    if (rx_msg_stored && control_reg[`CIRS_CTRL_RX_EN])
      next_flags[`CIRS_BIT_RX] = 1'b1;
    if (req_active) begin
      next_flags[`CIRS_BIT_OVR] = 1'b0;
      next_flags[`CIRS_BIT_TX]  = 1'b0;
      next_flags[`CIRS_BIT_RX]  = 1'b0;
    end
    next_flags[7:5] = 3'h0;
  end

  // edge detectors start at the idle levels so no false edge follows reset
  always @(posedge clk) begin
    if (sys_rst) begin
      irq_flag_reg <= `CIRS_FLAGS_RESET;
      err_status_q <= 1'b0;
      bus_off_q    <= 1'b0;
      tbs_q        <= 1'b1;
    end else begin
      irq_flag_reg <= next_flags;
      err_status_q <= error_warning_status;
      bus_off_q    <= bus_off_status;
      tbs_q        <= tx_buffer_released;
    end
  end

  assign can_irq_request = |irq_flag_reg[4:0];

  // --------------------------------------------------------------------------
  // system event status with write-one-to-clear and mask
  // --------------------------------------------------------------------------
  // bit0 bus-off entry, bit1 recovery done, bit2 wake
  // a write-one clear loses to an event in the same cycle
  always @(posedge clk) begin
    if (sys_rst) begin
      evt_status <= 3'h0;
      evt_mask   <= 3'h0;
    end else begin
      if (avs_write && avs_address == `CIRS_IDX_EVT_MASK)
        evt_mask <= avs_writedata[2:0];
      evt_status <= (evt_status
                     & ~((avs_write && avs_address == `CIRS_IDX_EVT) ?
                         avs_writedata[2:0] : 3'h0))
                    | {sleep_exit, rec_done, bus_off_rise};
    end
  end

  assign sys_irq = |(evt_status & evt_mask);

  // --------------------------------------------------------------------------
  // forced outputs under reset request
  // --------------------------------------------------------------------------
  // registered so the data outputs come from flip-flops
  // the forced values hold for as long as reset request stays high
  always @(posedge clk) begin
    if (sys_rst) begin
      test_mode_bit           <= 1'b0;
      sleep_cmd               <= 1'b0;
      clear_overrun_cmd       <= 1'b1;
      release_rx_buffer_cmd   <= 1'b1;
      abort_tx_cmd            <= 1'b0;
      tx_request_cmd          <= 1'b0;
      reference_output_enable <= 1'b1;
      rx_input0_select        <= 1'b1;
      rx_input1_select        <= 1'b1;
      status_reg              <= 8'h0C;
    end else if (req_active) begin
      test_mode_bit         <= 1'b0;
      sleep_cmd             <= 1'b0;
      clear_overrun_cmd     <= 1'b1;
      release_rx_buffer_cmd <= 1'b1;
      abort_tx_cmd          <= 1'b0;
      tx_request_cmd        <= 1'b0;
      status_reg[5:0]       <= 6'h0C;
      // after an external reset these are forced, otherwise they follow the core
      reference_output_enable <= ext_reset_latch ? 1'b1 : reference_in;
      rx_input0_select        <= ext_reset_latch ? 1'b1 : rx_input0_in;
      rx_input1_select        <= ext_reset_latch ? 1'b1 : rx_input1_in;
      status_reg[7]           <= ext_reset_latch ? 1'b0 : bus_off_status;
      status_reg[6]           <= ext_reset_latch ? 1'b0 : error_warning_status;
    end else begin
      test_mode_bit           <= test_mode_in;
      sleep_cmd               <= sleep_in;
      clear_overrun_cmd       <= clear_overrun_in;
      release_rx_buffer_cmd   <= release_rx_buffer_in;
      abort_tx_cmd            <= abort_tx_in;
      tx_request_cmd          <= tx_request_in;
      reference_output_enable <= reference_in;
      rx_input0_select        <= rx_input0_in;
      rx_input1_select        <= rx_input1_in;
      status_reg <= {bus_off_status, error_warning_status, tx_active_in, rx_active_in,
                     tx_complete_in, tx_buffer_released, next_overrun, next_rx_full};
    end
  end

  // --------------------------------------------------------------------------
  // read data
  // --------------------------------------------------------------------------
  // data captured on the waitrequest cycle; unmapped reads return zero
  // the flag word comes from next_flags so an event in the capture cycle is
  // reported before the read clear of the following edge removes it
  always @(posedge clk) begin
    if (sys_rst)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && !rd_ack) begin
      case (avs_address)
        `CIRS_IDX_FLAGS:    avs_readdata <= {24'h00_0000, next_flags};
        `CIRS_IDX_CTRL:     avs_readdata <= {24'h00_0000, control_reg};
        `CIRS_IDX_STATUS:   avs_readdata <= {24'h00_0000, status_reg};
        `CIRS_IDX_EVT:      avs_readdata <= {29'h0000_0000, evt_status};
        `CIRS_IDX_EVT_MASK: avs_readdata <= {29'h0000_0000, evt_mask};
        `CIRS_IDX_FORCED:   avs_readdata <= {30'h0000_0000, rec_busy, ext_reset_latch};
        default:            avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ===== test/cirs_top_assertions.sv
// port-level checker for the can interrupt flag block
`timescale 1ns/1ps
`include "cirs_defines.vh"
module cirs_top_checker #(
  parameter BUS_FREE_COUNT = `CIRS_BUS_FREE_CNT
) (
  // clock and reset
  input wire        clk,
  input wire        sys_rst,
  // bus
  input wire [3:0]  avs_address,
  input wire        avs_read,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  // events and outputs
  input wire        sleep_exit,
  input wire        overrun_store,
  input wire        rx_msg_stored,
  input wire        tx_buffer_released,
  input wire        error_warning_status,
  input wire        bus_off_enter,
  input wire        bus_free_pulse,
  input wire        test_mode_bit,
  input wire        sleep_cmd,
  input wire        clear_overrun_cmd,
  input wire        release_rx_buffer_cmd,
  input wire        abort_tx_cmd,
  input wire        tx_request_cmd,
  input wire [7:0]  status_reg,
  input wire        reset_request,
  input wire        can_irq_request
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // a flag read taken this cycle, with no wake, overrun, receive or bus-off event that could set a flag again
  wire flag_take = avs_read && !avs_waitrequest && avs_address == `CIRS_IDX_FLAGS;
  wire quiet     = !(sleep_exit || overrun_store || rx_msg_stored || bus_off_enter);
  wake_sets_irq_a: assert property (sleep_exit |=> can_irq_request)
    else $error("wake event left the interrupt low");
  busoff_sets_req_a: assert property (bus_off_enter |=> reset_request)
    else $error("bus-off entry did not raise reset request");
  forced_cmd_a: assert property (reset_request && $past(reset_request) |->
    !test_mode_bit && !sleep_cmd && clear_overrun_cmd && release_rx_buffer_cmd
    && !abort_tx_cmd && !tx_request_cmd) else $error("command view not forced");
  forced_status_a: assert property (reset_request && $past(reset_request) |->
    status_reg[5:0] == 6'b00_1100) else $error("status view not forced");
  read_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read answer not one cycle late");
  reserved_zero_a: assert property (flag_take |-> avs_readdata[31:5] == 27'h0)
    else $error("reserved flag bits not zero");
  read_clear_a: assert property (flag_take && quiet && !$past(bus_off_enter)
    && !$past(bus_free_pulse, 2) && $stable(tx_buffer_released)
    && $stable(error_warning_status) |=> !can_irq_request)
    else $error("flag read did not clear the interrupt");
  rbs_same_cycle_a: assert property ($rose(status_reg[0]) |-> $past(rx_msg_stored))
    else $error("buffer full status not tied to the receive event");
  ovr_same_cycle_a: assert property ($rose(status_reg[1]) |-> $past(overrun_store))
    else $error("overrun status not tied to the overrun event");
endmodule

bind cirs_top cirs_top_checker #(.BUS_FREE_COUNT(BUS_FREE_COUNT)) i_cirs_top_checker (
  .clk, .sys_rst, .avs_address, .avs_read, .avs_readdata, .avs_waitrequest,
  .sleep_exit, .overrun_store, .rx_msg_stored, .tx_buffer_released,
  .error_warning_status, .bus_off_enter, .bus_free_pulse, .test_mode_bit, .sleep_cmd,
  .clear_overrun_cmd, .release_rx_buffer_cmd, .abort_tx_cmd, .tx_request_cmd,
  .status_reg, .reset_request, .can_irq_request);

// ===== test/cirs_core_model.sv
// event model of the controller core that feeds the interrupt block
`timescale 1ns/1ps
module cirs_core_model (
  // clock and reset
  input  wire       clk,
  input  wire       sys_rst,
  // one-cycle requests from the bench
  input  wire [6:0] kick,
  // events into the block
  output reg        sleep_exit,
  output reg        overrun_store,
  output reg        rx_msg_stored,
  output reg        tx_buffer_released,
  output reg        error_warning_status,
  output reg        bus_off_enter,
  output reg        bus_free_pulse
);
  // pulses last one cycle; the tx buffer dips low one cycle so a release edge follows
  always @(posedge clk) begin
    sleep_exit           <= kick[0];
    overrun_store        <= kick[1];
    rx_msg_stored        <= kick[2];
    tx_buffer_released   <= ~kick[3];
    error_warning_status <= sys_rst ? 1'b0 : error_warning_status ^ kick[4];
    bus_off_enter        <= kick[5];
    bus_free_pulse       <= kick[6];
  end
endmodule

// ===== test/cirs_top_tb.sv
// self-checking bench for the can interrupt flag block
`timescale 1ns/1ps
`include "cirs_defines.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module cirs_top_tb;
  // ---------------------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------------------
  reg         clk = 1'b0;
  reg         sys_rst = 1'b1;
  reg  [3:0]  avs_address = 4'h0;
  reg         avs_read = 1'b0;
  reg         avs_write = 1'b0;
  reg  [31:0] avs_writedata = 32'h0000_0000;
  reg  [6:0]  kick = 7'h00;
  reg         ext_seen = 1'b0;
  reg  [11:0] raw = 12'hCC6;  // every raw level opposite to its forced value
  wire [31:0] avs_readdata;
  wire        avs_waitrequest;
  wire [6:0]  ev;
  wire [8:0]  cmd;
  wire [7:0]  status_reg;
  wire        reset_request;
  wire        error_counter_clear;
  wire        can_irq_request;
  wire        sys_irq;
  integer     n_mismatch = 0;
  integer     total_checks = 0;
  integer     n_clr = 0;
  integer     i;
  localparam [39:0] FBIT = {8'h04, 8'h02, 8'h01, 8'h08, 8'h10};
  always #2.5 clk = ~clk;
  // count counter-clear pulses so a missing or doubled one shows
  always @(posedge clk) if (error_counter_clear === 1'b1) n_clr <= n_clr + 1;
  // four bus-free pulses keep the recovery short
  cirs_top #(.BUS_FREE_COUNT(4)) i_cirs_top (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sleep_exit(ev[0]), .overrun_store(ev[1]),
    .rx_msg_stored(ev[2]), .tx_buffer_released(ev[3]), .error_warning_status(ev[4]),
    .bus_off_enter(ev[5]), .bus_free_pulse(ev[6]), .ext_reset_seen(ext_seen),
    .test_mode_in(raw[11]), .sleep_in(raw[10]), .clear_overrun_in(raw[9]),
    .release_rx_buffer_in(raw[8]), .abort_tx_in(raw[7]), .tx_request_in(raw[6]),
    .reference_in(raw[5]), .rx_input0_in(raw[4]), .rx_input1_in(raw[3]),
    .tx_active_in(raw[2]), .rx_active_in(raw[1]), .tx_complete_in(raw[0]),
    .test_mode_bit(cmd[8]), .sleep_cmd(cmd[7]), .clear_overrun_cmd(cmd[6]),
    .release_rx_buffer_cmd(cmd[5]), .abort_tx_cmd(cmd[4]), .tx_request_cmd(cmd[3]),
    .reference_output_enable(cmd[2]), .rx_input0_select(cmd[1]),
    .rx_input1_select(cmd[0]), .status_reg(status_reg), .reset_request(reset_request),
    .error_counter_clear(error_counter_clear), .can_irq_request(can_irq_request),
    .sys_irq(sys_irq));
  cirs_core_model i_cirs_core_model (
    .clk(clk), .sys_rst(sys_rst), .kick(kick), .sleep_exit(ev[0]), .overrun_store(ev[1]),
    .rx_msg_stored(ev[2]), .tx_buffer_released(ev[3]), .error_warning_status(ev[4]),
    .bus_off_enter(ev[5]), .bus_free_pulse(ev[6]));
  // ---------------------------------------------------------------------------
  // bus tasks: hold the request until waitrequest is seen low at an edge
  // ---------------------------------------------------------------------------
  task finish_test;
    begin
      if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task wait_ack;
    integer k;
    begin
      k = 0;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && k < 50) begin
        k = k + 1;
        @(posedge clk);
      end
      if (avs_waitrequest !== 1'b0) begin
        n_mismatch++;
        finish_test;
      end
    end
  endtask
  task rd(input [3:0] a, input [31:0] e);
    begin
      avs_address <= a;
      avs_read    <= 1'b1;
      wait_ack;
      `CHK(avs_readdata, e)
      avs_read <= 1'b0;
      @(posedge clk);
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      avs_address   <= a;
      avs_writedata <= {24'h00_0000, d};
      avs_write     <= 1'b1;
      wait_ack;
      avs_write <= 1'b0;
      // two more edges so the registered views settle before a check
      repeat (2) @(posedge clk);
    end
  endtask
  // one-cycle request to the core model, then time for model and flag to settle
  task pulse(input [6:0] m);
    begin
      kick <= m;
      @(posedge clk);
      kick <= 7'h00;
      repeat (4) @(posedge clk);
    end
  endtask
  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(`CIRS_IDX_CTRL, 32'h0000_0001);
    rd(`CIRS_IDX_FLAGS, 32'h0000_0000);
    `CHK(cmd, 9'b0_0110_0111)
    `CHK(status_reg, 8'h0C)
    wr(`CIRS_IDX_CTRL, 8'h1E);
    `CHK(cmd, raw[11:3])
    `CHK(status_reg[5:3], raw[2:0])
    // each event alone sets only its own flag, and a read clears it
    for (i = 0; i < 5; i = i + 1) begin
      pulse(7'h01 << i);
      `CHK(can_irq_request, 1'b1)
      rd(`CIRS_IDX_FLAGS, {24'h0, FBIT[i*8 +: 8]});
      `CHK(can_irq_request, 1'b0)
    end
    // reset request without a prior external reset: no reference forcing
    wr(`CIRS_IDX_CTRL, 8'h1F);
    `CHK(cmd, 9'b0_0110_0000)
    `CHK(status_reg[7:6], 2'b01)
    // an external reset under reset request brings the reference forcing back
    ext_seen <= 1'b1;
    @(posedge clk);
    ext_seen <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(cmd, 9'b0_0110_0111)
    `CHK(status_reg[7:6], 2'b00)
    rd(`CIRS_IDX_FORCED, 32'h0000_0001);
    pulse(7'h0E);
    rd(`CIRS_IDX_FLAGS, 32'h0000_0000);
    wr(`CIRS_IDX_FLAGS, 8'hFF);
    rd(`CIRS_IDX_FLAGS, 32'h0000_0000);
    // enables off: only the wake flag can latch
    wr(`CIRS_IDX_CTRL, 8'h00);
    pulse(7'h1F);
    rd(`CIRS_IDX_FLAGS, 32'h0000_0010);
    // bus-off entry and recovery after the cpu clears reset request
    wr(`CIRS_IDX_CTRL, 8'h1E);
    pulse(7'h20);
    `CHK(reset_request, 1'b1)
    `CHK(status_reg[7], 1'b1)
    rd(`CIRS_IDX_FLAGS, 32'h0000_0004);
    wr(`CIRS_IDX_CTRL, 8'h1E);
    repeat (3) pulse(7'h40);
    `CHK(status_reg[7], 1'b1)
    `CHK(n_clr, 0)
    pulse(7'h40);
    `CHK(status_reg[7], 1'b0)
    `CHK(n_clr, 1)
    rd(`CIRS_IDX_FLAGS, 32'h0000_0004);
    // sticky events, mask and write-one-to-clear
    rd(`CIRS_IDX_EVT, 32'h0000_0007);
    `CHK(sys_irq, 1'b0)
    wr(`CIRS_IDX_EVT_MASK, 8'h02);
    `CHK(sys_irq, 1'b1)
    wr(`CIRS_IDX_EVT, 8'h02);
    `CHK(sys_irq, 1'b0)
    rd(`CIRS_IDX_EVT, 32'h0000_0005);
    rd(4'hF, 32'h0000_0000);
    finish_test;
  end
endmodule
